// file: adc_seq_pkg.sv
// Shared constants for the converter sequencer and its host controller.
// Assumes a 250 MHz system clock on both ends.
package adc_seq_pkg;
   // ==========================================================
   // Clock and timing
   localparam int SYS_CLK_MHZ = 250;
   localparam int START_PULSE_NS = 30;
   localparam int START_PULSE_CYC = (START_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int ACQ_MIN_NS = 1400;
   localparam int ACQ_MIN_CYC = (ACQ_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int CONV_MAX_NS = 3700;
   localparam int CONV_MAX_CYC = (CONV_MAX_NS * SYS_CLK_MHZ) / 1000;
   localparam int CONV_CYC = CONV_MAX_CYC - 8;
   localparam int RESULT_BITS = 12;
   localparam int SCLK_HALF_CYC = 8;
   // ==========================================================
   // Variants and codes
   localparam logic VARIANT_SINGLE = 1'b0;
   localparam logic VARIANT_DIFF = 1'b1;
   localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
endpackage

// file: adc_link_if.sv
// Three-wire link between converter and host.
// Assumes the bench resolves the data wire from its output enable.
`timescale 1ns/1ps
interface adc_link_if;
   logic conversion_start_pin;
   logic shift_clock;
   logic serial_data;
   logic serial_data_oe;

   modport device (
      input conversion_start_pin,
      input shift_clock,
      output serial_data,
      output serial_data_oe
   );
   modport host (
      output conversion_start_pin,
      output shift_clock,
      input serial_data,
      input serial_data_oe
   );
endinterface

// file: adc_sequencer.sv
// Converter control end: tracks, holds, converts and shifts out a result.
// Assumes link pins come from another domain and are synchronised here.
//
// Overview of operation
// - Start rise powers up and tracks.
// - Start fall holds and begins converting.
// - Start pulse pattern chooses channel or polarity.
// - Single pulse selects first input channel.
// - Host double pulse of 36 ns selects second.
// - Short readout selects second channel next.
// - Host reads all 12 bits for first.
// - Host holds start high through acquisition.
// - Acquisition at least 1.4 us or computed.
// - MSB valid within 3.7 us of fall.
// - Shutdown automatically after conversion.
// - Data low from start until MSB.
// - After the MSB, data changes only on shift clock falls; a start rise during readout also drives it low.
// - Result shifted MSB first, 12 bits.
// - Data goes high impedance after readout.
// - Negative sample is ground or negative input.
// - Differential variant: same pattern selects bipolar.
// - Straight binary unipolar, offset binary bipolar.
// - Host samples data on shift clock rise.
`timescale 1ns/1ps
module adc_sequencer #(
   parameter logic VARIANT = adc_seq_pkg::VARIANT_SINGLE,
   parameter int BITS = adc_seq_pkg::RESULT_BITS
) (
   // System
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link
   adc_link_if.device link,
   // Analog front end abstraction
   input wire logic [BITS-1:0] sample_pos,
   input wire logic [BITS-1:0] sample_neg_input,
   output logic tracking,
   output logic powered,
   output logic channel_second,
   output logic bipolar,
   output logic neg_to_input,
   output logic [BITS-1:0] result
);
   typedef enum logic [2:0] {
      S_SHUTDOWN, S_TRACK, S_CONVERT, S_SHIFT
   } state_t;

   // ==========================================================
   // Pin synchronisers and edge detection
   logic [1:0] cnv_sync;
   logic [1:0] sck_sync;
   logic cnv_d;
   logic sck_d;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnv_sync <= 2'h0;
         sck_sync <= 2'h0;
         cnv_d <= 1'b0;
         sck_d <= 1'b0;
      end else begin
         cnv_sync <= {cnv_sync[0], link.conversion_start_pin};
         sck_sync <= {sck_sync[0], link.shift_clock};
         cnv_d <= cnv_sync[1];
         sck_d <= sck_sync[1];
      end
   end
   // Edges come from the second flop, so each pin costs two cycles.
   wire cnv_rise = cnv_sync[1] & ~cnv_d;
   wire cnv_fall = ~cnv_sync[1] & cnv_d;
   wire sck_fall = ~sck_sync[1] & sck_d;

   // ==========================================================
   // Sequencer state and datapath registers
   state_t state;
   logic [15:0] conv_cnt;
   logic [4:0] bit_cnt;
   logic [BITS-1:0] shreg;
   logic data;
   logic data_oe;
   logic [BITS-1:0] held_pos;
   logic [BITS-1:0] held_neg;

   // ==========================================================
   // Decoding
   wire [BITS-1:0] neg_sel = neg_to_input ? sample_neg_input
                                          : {BITS{1'b0}};
   wire [BITS-1:0] diff = held_pos - held_neg;
   wire [BITS-1:0] coded = bipolar ? (diff ^ adc_seq_pkg::BIPOLAR_FLIP)
                                   : diff;
   wire conv_done = conv_cnt == 16'(adc_seq_pkg::CONV_CYC);
   wire readout_short = bit_cnt < 5'(BITS);
   // A rise that arrives before the result is fully read picks the
   // alternate input; so does the second rise of a double pulse.
   wire pick_alt = state == S_TRACK || state == S_CONVERT ||
                   (state == S_SHIFT && readout_short);
   wire hold_now = state == S_TRACK && cnv_fall;
   wire finish_now = !cnv_rise && state == S_CONVERT && conv_done;
   wire shift_now = !cnv_rise && state == S_SHIFT && sck_fall;
   wire shift_bit = shift_now && readout_short;
   wire release_now = shift_now && !readout_short;

   assign neg_to_input = VARIANT == adc_seq_pkg::VARIANT_DIFF;
   assign tracking = state == S_TRACK;
   assign powered = state == S_TRACK || state == S_CONVERT;
   assign link.serial_data = data;
   assign link.serial_data_oe = data_oe;

   // ==========================================================
   // Control state
   // Any synchronised rise restarts tracking, whatever the state.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_SHUTDOWN;
      end else if (cnv_rise) begin
         state <= S_TRACK;
      end else begin
         unique case (state)
            S_SHUTDOWN: state <= S_SHUTDOWN;
            S_TRACK: begin
               if (hold_now) begin
                  state <= S_CONVERT;
               end
            end
            S_CONVERT: begin
               if (finish_now) begin
                  state <= S_SHIFT;
               end
            end
            S_SHIFT: begin
               if (release_now) begin
                  state <= S_SHUTDOWN;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Conversion timer and sample capture
   // The hold edge freezes both inputs; the timer stands in for the SAR.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         conv_cnt <= 16'h0;
         held_pos <= '0;
         held_neg <= '0;
      end else if (hold_now) begin
         conv_cnt <= 16'h0;
         held_pos <= sample_pos;
         held_neg <= neg_sel;
      end else if (state == S_CONVERT) begin
         conv_cnt <= conv_cnt + 16'h1;
      end
   end

   // ==========================================================
   // Result and shift register
   // The shift register keeps the bits still to be sent, next at the top.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         result <= '0;
         shreg <= '0;
         bit_cnt <= 5'h0;
      end else if (finish_now) begin
         result <= coded;
         shreg <= coded << 1;
         bit_cnt <= 5'h1;
      end else if (shift_bit) begin
         shreg <= shreg << 1;
         bit_cnt <= bit_cnt + 5'h1;
      end
   end

   // ==========================================================
   // Serial output
   // Data stays low from the start rise until the MSB lands.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         data <= 1'b0;
         data_oe <= 1'b0;
      end else if (cnv_rise) begin
         data <= 1'b0;
         data_oe <= 1'b1;
      end else if (finish_now) begin
         data <= coded[BITS-1];
      end else if (shift_bit) begin
         data <= shreg[BITS-1];
      end else if (release_now) begin
         data <= 1'b0;
         data_oe <= 1'b0;
      end
   end

   // ==========================================================
   // Channel and polarity selection
   // Both flags are taken at the rise and hold for the whole conversion.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         channel_second <= 1'b0;
         bipolar <= 1'b0;
      end else if (cnv_rise) begin
         channel_second <= pick_alt &&
                           VARIANT == adc_seq_pkg::VARIANT_SINGLE;
         bipolar <= pick_alt && VARIANT == adc_seq_pkg::VARIANT_DIFF;
      end
   end
endmodule

// file: adc_host.sv
// Host end: issues start pulses, waits, and reads the 12-bit result.
// Assumes data pin comes from another domain and is synchronised here.
`timescale 1ns/1ps
module adc_host #(
   parameter int BITS = adc_seq_pkg::RESULT_BITS,
   parameter int ACQ_CYC = adc_seq_pkg::ACQ_MIN_CYC
) (
   // System
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link
   adc_link_if.host link,
   // User request
   input wire logic req_valid,
   input wire logic req_second,
   output logic req_ready,
   output logic [BITS-1:0] rd_data,
   output logic rd_valid
);
   typedef enum logic [2:0] {
      H_IDLE, H_PRE_HI, H_PRE_LO, H_ACQ, H_WAIT, H_CLK_LO, H_CLK_HI
   } hstate_t;

   hstate_t state;
   logic [15:0] cnt;
   logic [4:0] nbits;
   logic [1:0] din_sync;
   logic cnv;
   logic sck;
   logic [BITS-1:0] sreg;

   localparam int WAIT_CYC = (adc_seq_pkg::CONV_MAX_NS *
                              adc_seq_pkg::SYS_CLK_MHZ + 999) / 1000 + 4;
   localparam int ACQ_USE = ACQ_CYC < adc_seq_pkg::ACQ_MIN_CYC
                            ? adc_seq_pkg::ACQ_MIN_CYC : ACQ_CYC;
   wire cnt_hit_pulse = cnt == 16'(adc_seq_pkg::START_PULSE_CYC);
   wire cnt_hit_acq = cnt == 16'(ACQ_USE);
   wire cnt_hit_wait = cnt == 16'(WAIT_CYC);
   wire cnt_hit_half = cnt == 16'(adc_seq_pkg::SCLK_HALF_CYC);

   assign req_ready = state == H_IDLE;
   assign link.conversion_start_pin = cnv;
   assign link.shift_clock = sck;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         din_sync <= 2'h0;
      end else begin
         din_sync <= {din_sync[0], link.serial_data};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= H_IDLE;
         cnt <= 16'h0;
         nbits <= 5'h0;
         cnv <= 1'b0;
         sck <= 1'b0;
         sreg <= '0;
         rd_data <= '0;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         cnt <= cnt + 16'h1;
         unique case (state)
            H_IDLE: begin
               if (req_valid) begin
                  cnv <= 1'b1;
                  cnt <= 16'h0;
                  state <= req_second ? H_PRE_HI : H_ACQ;
               end
            end
            H_PRE_HI: if (cnt_hit_pulse) begin
               cnv <= 1'b0;
               cnt <= 16'h0;
               state <= H_PRE_LO;
            end
            H_PRE_LO: if (cnt_hit_pulse) begin
               cnv <= 1'b1;
               cnt <= 16'h0;
               state <= H_ACQ;
            end
            H_ACQ: if (cnt_hit_acq) begin
               cnv <= 1'b0;
               cnt <= 16'h0;
               state <= H_WAIT;
            end
            H_WAIT: if (cnt_hit_wait) begin
               cnt <= 16'h0;
               nbits <= 5'h0;
               state <= H_CLK_LO;
            end
            H_CLK_LO: if (cnt_hit_half) begin
               sck <= 1'b1;
               sreg <= {sreg[BITS-2:0], din_sync[1]};
               nbits <= nbits + 5'h1;
               cnt <= 16'h0;
               state <= H_CLK_HI;
            end
            H_CLK_HI: if (cnt_hit_half) begin
               sck <= 1'b0;
               cnt <= 16'h0;
               if (nbits == 5'(BITS)) begin
                  rd_data <= sreg;
                  rd_valid <= 1'b1;
                  state <= H_IDLE;
               end else begin
                  state <= H_CLK_LO;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
endmodule

// file: adc_link_monitor.sv
// Checker for the three-wire link between the two ends.
// Assumes one system clock domain shared by both ends.
`timescale 1ns/1ps
module adc_link_monitor (
   // System
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link
   input wire logic conversion_start_pin,
   input wire logic shift_clock,
   input wire logic serial_data,
   input wire logic serial_data_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   logic [15:0] hi_cnt;
   logic [15:0] lo_cnt;
   logic [15:0] last_hi;
   logic [4:0] fall_cnt;
   logic sck_q;
   wire cnv = conversion_start_pin;
   wire [15:0] next_hi = !cnv ? 16'h0 : hi_cnt + {15'h0, ~&hi_cnt};
   wire [15:0] next_lo = cnv ? 16'h0 : lo_cnt + {15'h0, ~&lo_cnt};
   wire [15:0] next_last = (!cnv && hi_cnt != 16'h0) ? hi_cnt : last_hi;
   wire sck_fall = sck_q && !shift_clock;
   wire [4:0] next_fall = cnv ? 5'h0 :
      fall_cnt + {4'h0, sck_fall && ~&fall_cnt};
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt <= 16'h0;
         lo_cnt <= 16'hffff;
         last_hi <= 16'h0;
         fall_cnt <= 5'h0;
         sck_q <= 1'b0;
      end else begin
         hi_cnt <= next_hi;
         lo_cnt <= next_lo;
         last_hi <= next_last;
         fall_cnt <= next_fall;
         sck_q <= shift_clock;
      end
   end
   // ==========================================================
   // Properties
   property p_rise_low;
      $rose(cnv) |-> ##[1:6] (serial_data_oe && !serial_data);
   endproperty
   a_rise_low: assert property (p_rise_low) else $error("no low on start");
   property p_conv_low;
      $fell(cnv) |-> ##4 (serial_data_oe && !serial_data) [*8];
   endproperty
   a_conv_low: assert property (p_conv_low) else $error("data not low");
   property p_stable_high;
      shift_clock [*6] |-> $stable(serial_data);
   endproperty
   a_stable_high: assert property (p_stable_high) else $error("bad edge");
   property p_wait_conv;
      $rose(shift_clock) |-> lo_cnt >= adc_seq_pkg::CONV_MAX_CYC;
   endproperty
   a_wait_conv: assert property (p_wait_conv) else $error("early clock");
   property p_acq;
      $rose(shift_clock) |-> last_hi >= adc_seq_pkg::ACQ_MIN_CYC;
   endproperty
   a_acq: assert property (p_acq) else $error("short acquisition");
   property p_low_pulse;
      $rose(cnv) |-> $past(lo_cnt) >= adc_seq_pkg::START_PULSE_CYC;
   endproperty
   a_low_pulse: assert property (p_low_pulse) else $error("short low");
   property p_high_pulse;
      $fell(cnv) |-> $past(hi_cnt) >= adc_seq_pkg::START_PULSE_CYC;
   endproperty
   a_high_pulse: assert property (p_high_pulse) else $error("short high");
   property p_release;
      $fell(serial_data_oe) |-> fall_cnt >= 5'h0c;
   endproperty
   a_release: assert property (p_release) else $error("early release");
   property p_idle_clk;
      cnv |-> !shift_clock;
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("clock in track");
endmodule

// file: adc_conversion_sequencer_serial_out_tb_top.sv
// Bench joining both ends over two links, one per variant.
// Assumes package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
module adc_conversion_sequencer_serial_out_tb_top;
   logic clk_sys;
   logic rst_n;
   logic host_rst_n;
   logic req_valid;
   logic req_second;
   logic [11:0] pos;
   logic [11:0] neg;
   logic [11:0] got [2];
   logic [11:0] p;
   integer n_fail;
   integer check_count;
   integer seed;
   integer cycles;
   wire [1:0] req_ready;
   wire [1:0] rd_valid;
   wire [1:0] tracking;
   wire [1:0] powered;
   wire [1:0] chan2;
   wire [1:0] bip;
   wire [1:0] neg_in;
   wire [11:0] rd_data [2];
   wire [11:0] result [2];
   adc_link_if link [2] ();
   wire [1:0] oe = {link[1].serial_data_oe, link[0].serial_data_oe};
   for (genvar g = 0; g < 2; g++) begin : gen_end
      adc_sequencer #(.VARIANT(g == 1)) adc_sequencer_inst (
         .clk_sys(clk_sys), .rst_n(rst_n), .link(link[g]),
         .sample_pos(pos), .sample_neg_input(neg),
         .tracking(tracking[g]), .powered(powered[g]),
         .channel_second(chan2[g]), .bipolar(bip[g]),
         .neg_to_input(neg_in[g]), .result(result[g]));
      adc_host adc_host_inst (
         .clk_sys(clk_sys), .rst_n(host_rst_n), .link(link[g]),
         .req_valid(req_valid), .req_second(req_second),
         .req_ready(req_ready[g]), .rd_data(rd_data[g]),
         .rd_valid(rd_valid[g]));
   end
   adc_link_monitor adc_link_monitor_inst (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .conversion_start_pin(link[0].conversion_start_pin),
      .shift_clock(link[0].shift_clock),
      .serial_data(link[0].serial_data),
      .serial_data_oe(link[0].serial_data_oe));
   // ==========================================================
   // Helpers
   function automatic logic [11:0] code(int v, logic [11:0] a,
      logic [11:0] b, logic s);
      if (v == 0) begin
         return a;
      end
      return s ? (a - b) ^ adc_seq_pkg::BIPOLAR_FLIP : a - b;
   endfunction
   task automatic chk(input logic [11:0] val, input logic [11:0] exp);
      check_count++;
      if (val !== exp) begin
         $display("unexpected at %0t: got %h want %h", $time, val, exp);
         n_fail++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic run(input logic s, input logic alt, input logic [11:0] a,
      input logic [11:0] b);
      int k;
      logic [1:0] seen;
      logic m;
      m = s | alt;
      @(negedge clk_sys);
      while (req_ready !== 2'b11) @(negedge clk_sys);
      pos = a;
      neg = b;
      req_second = s;
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      chk({10'h0, req_ready}, 12'h0);
      repeat (100) @(negedge clk_sys);
      chk({10'h0, tracking & powered}, 12'h3);
      repeat (400) @(negedge clk_sys);
      chk({10'h0, tracking}, 12'h0);
      chk({10'h0, powered}, 12'h3);
      seen = 2'b00;
      k = 0;
      while (seen != 2'b11 && k < 3000) begin
         @(negedge clk_sys);
         for (int i = 0; i < 2; i++) begin
            if (rd_valid[i] === 1'b1) begin
               got[i] = rd_data[i];
               seen[i] = 1'b1;
            end
         end
         k++;
      end
      chk({10'h0, seen}, 12'h3);
      repeat (30) @(negedge clk_sys);
      chk({10'h0, oe}, 12'h0);
      chk({10'h0, powered}, 12'h0);
      chk({10'h0, neg_in}, 12'h2);
      chk({10'h0, bip[1], chan2[0]}, {10'h0, m, m});
      for (int i = 0; i < 2; i++) begin
         chk(got[i], code(i, a, b, m));
         chk(result[i], code(i, a, b, m));
      end
   endtask
   // ==========================================================
   // Clock, timeout and sequence
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      seed = 32'h88dbfeeb;
      n_fail = 0;
      check_count = 0;
      cycles = 0;
      rst_n = 1'b0;
      host_rst_n = 1'b0;
      req_valid = 1'b0;
      req_second = 1'b0;
      pos = 12'h000;
      neg = 12'h000;
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      host_rst_n = 1'b1;
      run(1'b0, 1'b0, 12'hfff, 12'h000);
      run(1'b1, 1'b0, 12'hfff, 12'hfff);
      run(1'b1, 1'b0, 12'h000, 12'h000);
      run(1'b0, 1'b0, 12'h801, 12'h001);
      // Abandon a readout part way by resetting the host alone.
      @(negedge clk_sys);
      req_second = 1'b0;
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      repeat (1320) @(negedge clk_sys);
      host_rst_n = 1'b0;
      @(negedge clk_sys);
      host_rst_n = 1'b1;
      run(1'b0, 1'b1, 12'h5a3, 12'h0c1);
      for (int j = 0; j < 6; j++) begin
         p = 12'($random(seed));
         run(1'($random(seed)), 1'b0, p,
             12'($unsigned($random(seed)) % (p + 1)));
      end
      conclude();
   end
endmodule
